//--- rtl/ssp_top.sv
// serial shift port core with AHB-Lite register slave and pin drivers
//
// Overview of operation
// RULE1 - eight-bit shift register, four-bit edge counter
// RULE2 - data leaves most significant bit first
// RULE3 - shift and count on clock falling edge
// RULE4 - shift left, sample input into bit zero
// RULE5 - slave mode: partner drives the clock pin
// RULE6 - master mode: software toggles clock pin
// RULE7 - after eight edges counter blocks further shifting
// RULE8 - eighth edge interrupts unless data write intervenes
// RULE9 - interrupt disarmed after reset
// RULE10 - data write arms, disable write disarms
// RULE11 - interrupt signalled as high-to-low transition
// RULE12 - reset or data write clears counter
// RULE13 - data-out open-drain, data-in input only (code pulls data-in low while SSP_CTRL_ACK is set)
// RULE14 - open-drain data-out carries shift register output
// RULE15 - slave may stretch clock by holding low
// RULE16 - ninth pulse acknowledge by pulling data-in low
// RULE17 - start via data-in fall, stop polled
// RULE18 - chip-select external; data pins may tie
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module ssp_top #(
    parameter int unsigned ADDR_W = ssp_pkg::SSP_ADDR_W
) (
    input  wire logic                            hclk,
    input  wire logic                            hresetn,
    input  wire logic                            hsel,
    input  wire logic [ADDR_W-1:0]               haddr,
    input  wire logic [1:0]                      htrans,
    input  wire logic                            hwrite,
    input  wire logic [2:0]                      hsize,
    input  wire logic [ssp_pkg::SSP_DATA_W-1:0]  hwdata,
    input  wire logic                            hready,
    output logic      [ssp_pkg::SSP_DATA_W-1:0]  hrdata,
    output logic                                 hreadyout,
    output logic                                 hresp,
    output logic                                 irq,
    output logic                                 shift_irq_n,
    input  wire logic                            scl_i,
    output logic                                 scl_o,
    output logic                                 scl_oe,
    input  wire logic                            sin_i,
    output logic                                 sin_o,
    output logic                                 sin_oe,
    output logic                                 sout_o,
    output logic                                 sout_oe
);
    import ssp_pkg::*;

    if (ADDR_W < 10) begin : g_bad_addr
        $error("ssp_top needs at least ten address bits");
    end

    typedef struct packed {
        ssp_bus_e                bus;
        logic                    wr_pend;
        logic [7:0]              idx;
        logic [SSP_DATA_W-1:0]   rdata;
        logic                    ready;
        // RULE1 eight-bit shifter, four-bit counter
        logic [SSP_BYTE_W-1:0]   shreg;
        logic [SSP_CNT_W-1:0]    cnt;
        logic                    armed;
        logic                    irq_n;
        logic [SSP_CTRL_W-1:0]   ctrl;
        logic [SSP_ST_W-1:0]     stat;
        logic [SSP_ST_W-1:0]     mask;
        logic                    irq;
        logic                    scl_oe;
        logic                    sin_oe;
        logic                    sout_oe;
    } ssp_state_s;

    ssp_state_s st_reg;
    ssp_state_s st_next;

    ssp_pin_if pins ();

    ssp_pin_sync #(
        .STAGES (SSP_SYNC_STAGES)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .scl_i   (scl_i),
        .sin_i   (sin_i),
        .pins    (pins)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic       addr_take;
    logic       in_range;
    logic [7:0] addr_idx;
    logic       wr_data;
    logic       wr_dis;
    logic       wr_ctrl;
    logic       wr_stat;
    logic       wr_mask;
    logic       shift_ok;
    logic       byte_end;
    logic [SSP_ST_W-1:0] events;

    assign addr_take = hsel & htrans[1] & hready;
    assign addr_idx  = haddr[9:2];
    assign in_range  = (haddr[ADDR_W-1:10] == '0);

    assign wr_data = st_reg.wr_pend & (st_reg.idx == SSP_IDX_SHIFT_DATA);
    assign wr_dis  = st_reg.wr_pend & (st_reg.idx == SSP_IDX_INT_DISABLE);
    assign wr_ctrl = st_reg.wr_pend & (st_reg.idx == SSP_IDX_CTRL);
    assign wr_stat = st_reg.wr_pend & (st_reg.idx == SSP_IDX_STAT);
    assign wr_mask = st_reg.wr_pend & (st_reg.idx == SSP_IDX_MASK);

    ////////////////////////////////////////////////////////////////////////////////////////
    // shift engine

    // RULE7 terminal count gate
    // count_done_output is low once bit three of the counter is set
    logic count_done_output;
    assign count_done_output = ~st_reg.cnt[SSP_CNT_W-1];
    // RULE3 falling edge advances
    assign shift_ok = pins.scl_fall & count_done_output;
    assign byte_end = shift_ok & (st_reg.cnt == SSP_CNT_FULL - 4'h1);

    // RULE17 start and stop seen while the clock sits high
    assign events = {pins.sin_rise & pins.scl_lvl,
                     pins.sin_fall & pins.scl_lvl,
                     byte_end & st_reg.armed};

    always_comb begin
        st_next = st_reg;

        // a read waits one cycle so it sees any write still in its data phase
        st_next.wr_pend = 1'b0;
        st_next.ready   = 1'b1;
        st_next.bus     = SSP_BS_IDLE;
        case (st_reg.bus)
            SSP_BS_IDLE: begin
                if (addr_take && in_range) begin
                    st_next.idx     = addr_idx;
                    st_next.wr_pend = hwrite;
                    if (!hwrite) begin
                        st_next.bus   = SSP_BS_RDATA;
                        st_next.ready = 1'b0;
                    end
                end else if (addr_take) begin
                    st_next.idx = 8'h00;
                end
            end
            SSP_BS_RDATA: begin
                case (st_reg.idx)
                    SSP_IDX_SHIFT_DATA: st_next.rdata = {24'h000000, st_reg.shreg};
                    SSP_IDX_CTRL:       st_next.rdata = {27'h0000000, st_reg.ctrl};
                    SSP_IDX_STAT:       st_next.rdata = {29'h00000000, st_reg.stat};
                    SSP_IDX_MASK:       st_next.rdata = {29'h00000000, st_reg.mask};
                    SSP_IDX_PINS: begin
                        st_next.rdata = 32'h00000000;
                        st_next.rdata[SSP_PIN_SCL]   = pins.scl_lvl;
                        st_next.rdata[SSP_PIN_SIN]   = pins.sin_lvl;
                        st_next.rdata[SSP_PIN_ARMED] = st_reg.armed;
                        st_next.rdata[SSP_PIN_DONE]  = ~count_done_output;
                        st_next.rdata[SSP_PIN_CNT +: SSP_CNT_W] = st_reg.cnt;
                    end
                    default:            st_next.rdata = 32'h00000000;
                endcase
            end
            default: begin
                st_next.bus = SSP_BS_IDLE;
            end
        endcase

        // RULE4 shift toward msb, sample input
        if (shift_ok) begin
            st_next.shreg = {st_reg.shreg[SSP_BYTE_W-2:0], pins.sin_lvl};
            st_next.cnt   = st_reg.cnt + 4'h1;
        end

        // RULE8 eighth edge drops the request
        // RULE11 request is a falling level
        if (byte_end && st_reg.armed) begin
            st_next.irq_n = 1'b0;
        end

        // RULE12 data write restarts counter
        // RULE10 data write arms the interrupt
        if (wr_data) begin
            st_next.shreg = hwdata[SSP_BYTE_W-1:0];
            st_next.cnt   = SSP_CNT_RST;
            st_next.armed = 1'b1;
            st_next.irq_n = 1'b1;
        end
        // RULE10 any disable write disarms
        if (wr_dis) begin
            st_next.armed = 1'b0;
            st_next.irq_n = 1'b1;
        end

        if (wr_ctrl) begin
            st_next.ctrl = hwdata[SSP_CTRL_W-1:0];
        end
        if (wr_mask) begin
            st_next.mask = hwdata[SSP_ST_W-1:0];
        end
        // new events win over a clearing write in the same cycle
        if (wr_stat) begin
            st_next.stat = st_reg.stat & ~hwdata[SSP_ST_W-1:0];
        end
        st_next.stat = st_next.stat | events;
        st_next.irq  = |(st_next.stat & st_next.mask);

        // RULE5 slave leaves the clock pin an input
        // RULE6 master drives the software clock level
        // RULE15 stretch holds clock low
        st_next.scl_oe = (st_next.ctrl[SSP_CTRL_MASTER] & ~st_next.ctrl[SSP_CTRL_SCL_LVL])
                       | st_next.ctrl[SSP_CTRL_STRETCH];
        // RULE16 acknowledge pulls data-in low
        // RULE13 data-in is otherwise never driven
        st_next.sin_oe = st_next.ctrl[SSP_CTRL_ACK];
        // RULE2 msb presented first
        // RULE14 open-drain enable routes the shift msb
        // RULE18 released high so tied data pins share one wire
        st_next.sout_oe = st_next.ctrl[SSP_CTRL_SOUT_OD] & ~st_next.shreg[SSP_BYTE_W-1];
    end

    // RULE9 reset leaves the interrupt disarmed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg         <= '0;
            st_reg.bus     <= SSP_BS_IDLE;
            st_reg.ready   <= 1'b1;
            st_reg.shreg   <= SSP_DATA_RST;
            st_reg.cnt     <= SSP_CNT_RST;
            st_reg.irq_n   <= 1'b1;
            st_reg.ctrl    <= SSP_CTRL_RST;
            st_reg.mask    <= SSP_MASK_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hrdata      = st_reg.rdata;
    assign hreadyout   = st_reg.ready;
    assign hresp       = 1'b0;
    assign irq         = st_reg.irq;
    assign shift_irq_n = st_reg.irq_n;
    assign scl_o       = 1'b0;
    assign scl_oe      = st_reg.scl_oe;
    assign sin_o       = 1'b0;
    assign sin_oe      = st_reg.sin_oe;
    assign sout_o      = 1'b0;
    assign sout_oe     = st_reg.sout_oe;

    ////////////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // RULE7 counter stops at eight
    a_count_stops: assert property (st_reg.cnt == SSP_CNT_FULL && !wr_data
                                    |=> st_reg.cnt == SSP_CNT_FULL) // RULE7
        else $error("counter moved past eight");

    // RULE1 counter never exceeds eight
    a_count_range: assert property (st_reg.cnt <= SSP_CNT_FULL) // RULE1
        else $error("counter out of range");

    // RULE4 shift samples data-in into bit zero
    a_shift_sample: assert property (shift_ok && !wr_data
                                     |=> st_reg.shreg[0] == $past(pins.sin_lvl)
                                         && st_reg.shreg[7:1] == $past(st_reg.shreg[6:0])) // RULE4
        else $error("shift did not move data");

    // RULE3 no falling edge, no shift
    a_hold_no_edge: assert property (!pins.scl_fall && !wr_data
                                     |=> $stable(st_reg.shreg) && $stable(st_reg.cnt)) // RULE3
        else $error("shift without clock edge");

    // RULE8 armed eighth edge drops request
    a_irq_on_eighth: assert property (byte_end && st_reg.armed && !wr_data && !wr_dis
                                      |=> !shift_irq_n && st_reg.stat[SSP_ST_DONE]) // RULE8
        else $error("no request on eighth edge");

    // RULE8 masked level follows status
    a_irq_level: assert property (irq == |(st_reg.stat & st_reg.mask)) // RULE8
        else $error("level request disagrees with status");

    // RULE10 disarmed port never requests
    a_disarmed_quiet: assert property (!st_reg.armed && shift_irq_n
                                       && !wr_data |=> shift_irq_n) // RULE10
        else $error("request while disarmed");

    // RULE10 disable write drops the arm
    a_disable_clears: assert property (wr_dis |=> !st_reg.armed && shift_irq_n) // RULE10
        else $error("disable write did not disarm");

    // RULE12 data write loads and clears
    a_write_loads: assert property (wr_data |=> st_reg.cnt == SSP_CNT_RST && st_reg.armed
                                    && st_reg.shreg == $past(hwdata[7:0])) // RULE12
        else $error("data write did not restart");

    // RULE11 request only ever falls on a byte end
    a_irq_fall_cause: assert property ($fell(shift_irq_n)
                                       |-> $past(byte_end) && $past(st_reg.armed)) // RULE11
        else $error("request fell without byte end");

    // RULE14 data-out driven only by open-drain mode and a low msb
    a_sout_follows: assert property (sout_oe |-> st_reg.ctrl[SSP_CTRL_SOUT_OD]
                                     && !st_reg.shreg[7]) // RULE14
        else $error("data-out driven wrongly");

    // RULE5 slave without stretch never drives the clock
    a_slave_clock: assert property (!st_reg.ctrl[SSP_CTRL_MASTER]
                                    && !st_reg.ctrl[SSP_CTRL_STRETCH] |-> !scl_oe) // RULE5
        else $error("slave drove the clock pin");

    // RULE6 master low level pulls the clock
    a_master_low: assert property (st_reg.ctrl[SSP_CTRL_MASTER]
                                   && !st_reg.ctrl[SSP_CTRL_SCL_LVL] |-> scl_oe) // RULE6
        else $error("master clock level not driven");

    // RULE16 acknowledge bit drives data-in
    a_ack_drive: assert property (sin_oe == st_reg.ctrl[SSP_CTRL_ACK]) // RULE16
        else $error("acknowledge drive wrong");

    // RULE17 start event lands in status
    a_start_flag: assert property (events[SSP_ST_START] |=> st_reg.stat[SSP_ST_START]) // RULE17
        else $error("start event lost");

    // RULE15 stretch holds the clock low a cycle later
    a_stretch_low: assert property (wr_ctrl && hwdata[SSP_CTRL_STRETCH]
                                    |=> scl_oe && !scl_o) // RULE15
        else $error("stretch not applied");

    a_read_ready: assert property (st_reg.bus == SSP_BS_RDATA |-> !hreadyout ##1 hreadyout)
        else $error("read wait not one cycle");

    c_byte_done: cover property (byte_end && st_reg.armed);
    c_stretch_held: cover property (st_reg.ctrl[SSP_CTRL_STRETCH] && scl_oe);
    c_start_seen: cover property (events[SSP_ST_START]);
    c_stat_race: cover property (wr_stat && |events);
    c_disarm: cover property (wr_dis ##1 !st_reg.armed);
endmodule

//--- include/ssp_pkg.sv
// constants, register map and types shared by the serial shift port files
package ssp_pkg;
    localparam int unsigned SSP_ADDR_W     = 12;
    localparam int unsigned SSP_DATA_W     = 32;
    localparam int unsigned SSP_BYTE_W     = 8;
    localparam int unsigned SSP_CNT_W      = 4;
    localparam int unsigned SSP_SYNC_STAGES = 2;

    // register indices; byte address is four times the index
    localparam logic [7:0] SSP_IDX_INT_DISABLE = 8'hc2;
    localparam logic [7:0] SSP_IDX_SHIFT_DATA  = 8'hdd;
    localparam logic [7:0] SSP_IDX_CTRL        = 8'he0;
    localparam logic [7:0] SSP_IDX_STAT        = 8'he1;
    localparam logic [7:0] SSP_IDX_MASK        = 8'he2;
    localparam logic [7:0] SSP_IDX_PINS        = 8'he3;

    // control field positions
    localparam int unsigned SSP_CTRL_MASTER  = 0;
    localparam int unsigned SSP_CTRL_SCL_LVL = 1;
    localparam int unsigned SSP_CTRL_SOUT_OD = 2;
    localparam int unsigned SSP_CTRL_ACK     = 3;
    localparam int unsigned SSP_CTRL_STRETCH = 4;
    localparam int unsigned SSP_CTRL_W       = 5;

    // status and mask field positions
    localparam int unsigned SSP_ST_DONE  = 0;
    localparam int unsigned SSP_ST_START = 1;
    localparam int unsigned SSP_ST_STOP  = 2;
    localparam int unsigned SSP_ST_W     = 3;

    // pins register field positions
    localparam int unsigned SSP_PIN_SCL   = 0;
    localparam int unsigned SSP_PIN_SIN   = 1;
    localparam int unsigned SSP_PIN_ARMED = 2;
    localparam int unsigned SSP_PIN_DONE  = 3;
    localparam int unsigned SSP_PIN_CNT   = 4;

    // reset values
    localparam logic [SSP_CTRL_W-1:0] SSP_CTRL_RST  = 5'h02;
    localparam logic [SSP_ST_W-1:0]   SSP_MASK_RST  = 3'h0;
    localparam logic [SSP_BYTE_W-1:0] SSP_DATA_RST  = 8'h00;
    localparam logic [SSP_CNT_W-1:0]  SSP_CNT_RST   = 4'h0;
    localparam logic [SSP_CNT_W-1:0]  SSP_CNT_FULL  = 4'h8;

    typedef enum logic [0:0] {
        SSP_BS_IDLE,
        SSP_BS_RDATA
    } ssp_bus_e;
endpackage

//--- include/ssp_pin_if.sv
// synchronised pin levels and edges passed from the pin sampler to the port core
`timescale 1ns/1ps
interface ssp_pin_if;
    logic scl_lvl;
    logic sin_lvl;
    logic scl_fall;
    logic sin_fall;
    logic sin_rise;

    modport sampler (
        output scl_lvl,
        output sin_lvl,
        output scl_fall,
        output sin_fall,
        output sin_rise
    );
    modport core (
        input scl_lvl,
        input sin_lvl,
        input scl_fall,
        input sin_fall,
        input sin_rise
    );
endinterface

//--- rtl/ssp_pin_sync.sv
// two-flop synchroniser and edge finder for the clock and data-in pins
`timescale 1ns/1ps
module ssp_pin_sync #(
    parameter int unsigned STAGES = ssp_pkg::SSP_SYNC_STAGES
) (
    input  wire logic      hclk,
    input  wire logic      hresetn,
    input  wire logic      scl_i,
    input  wire logic      sin_i,
    ssp_pin_if.sampler     pins
);
    import ssp_pkg::*;

    typedef struct packed {
        logic [STAGES-1:0] scl_sh;
        logic [STAGES-1:0] sin_sh;
        logic              scl_old;
        logic              sin_old;
    } ssp_sync_s;

    ssp_sync_s sync_reg;
    ssp_sync_s sync_next;

    if (STAGES < 2) begin : g_bad_stages
        $error("ssp_pin_sync needs at least two stages");
    end

    // only the last stage is read; the first stage feeds the second alone
    always_comb begin
        sync_next         = sync_reg;
        sync_next.scl_sh  = {sync_reg.scl_sh[STAGES-2:0], scl_i};
        sync_next.sin_sh  = {sync_reg.sin_sh[STAGES-2:0], sin_i};
        sync_next.scl_old = sync_reg.scl_sh[STAGES-1];
        sync_next.sin_old = sync_reg.sin_sh[STAGES-1];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_reg <= '1;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign pins.scl_lvl  = sync_reg.scl_sh[STAGES-1];
    assign pins.sin_lvl  = sync_reg.sin_sh[STAGES-1];
    assign pins.scl_fall = sync_reg.scl_old & ~sync_reg.scl_sh[STAGES-1];
    assign pins.sin_fall = sync_reg.sin_old & ~sync_reg.sin_sh[STAGES-1];
    assign pins.sin_rise = ~sync_reg.sin_old & sync_reg.sin_sh[STAGES-1];
endmodule

//--- sim/ssp_link_model.sv
// external serial bus party: supplies the shift clock and data-in level
`timescale 1ns/1ps
module ssp_link_model (
    input  wire logic scl_line,
    input  wire logic sout_line,
    output logic      scl_drv,
    output logic      sin_drv
);
    localparam time HALF = 400ns;
    // step off the hclk edge so pin changes never race the synchroniser
    localparam time SKEW = 10ns;

    initial begin
        scl_drv = 1'b1;
        sin_drv = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // external clock supply
    // clock stands high between frames; data is set while the clock is high, so
    // start/stop status bits may be set as a side effect of plain shifting
    task automatic clk_bits(input int n, input logic [7:0] tx, output logic [7:0] rx);
        int k;
        #(SKEW);
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            sin_drv = tx[7-i];
            #(HALF/2);
            rx = {rx[6:0], sout_line};
            scl_drv = 1'b0;
            #(HALF);
            scl_drv = 1'b1;
            k = 0;
            // a stretching slave holds the line low; wait it out, bounded
            while (scl_line !== 1'b1 && k < 100) begin
                #100;
                k++;
            end
            if (scl_line !== 1'b1) ssp_top_tb.errors++;
            #(HALF/2);
        end
        // released data line floats back to its pull-up
        sin_drv = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // start and stop
    task automatic start_cond();
        #(SKEW);
        sin_drv = 1'b0;
        #(HALF);
    endtask

    task automatic stop_cond();
        #(SKEW);
        sin_drv = 1'b1;
        #(HALF);
    endtask
endmodule

//--- sim/ssp_top_tb.sv
// self-checking bench for the serial shift port: bus tasks, pin wiring, scenarios
`timescale 1ns/1ps
module ssp_top_tb;
    import ssp_pkg::*;
    logic                  hclk;
    logic                  hresetn;
    logic                  hsel;
    logic [SSP_ADDR_W-1:0] haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [SSP_DATA_W-1:0] hwdata;
    logic [SSP_DATA_W-1:0] hrdata;
    logic                  hreadyout;
    logic                  hresp;
    logic                  irq;
    logic                  shift_irq_n;
    logic                  scl_o;
    logic                  scl_oe;
    logic                  sin_o;
    logic                  sin_oe;
    logic                  sout_o;
    logic                  sout_oe;
    logic                  scl_drv;
    logic                  sin_drv;
    wire                   scl_line;
    wire                   sin_line;
    wire                   sout_line;
    int                    errors;
    int                    n_checks;

    initial hclk = 1'b0;
    always #50 hclk = ~hclk;

    // three-wire hookup, chip-select lives outside the block
    assign scl_line  = scl_oe ? scl_o : scl_drv;
    assign sin_line  = sin_oe ? sin_o : sin_drv;
    assign sout_line = sout_oe ? sout_o : 1'b1;

    ssp_top dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .shift_irq_n(shift_irq_n), .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe),
        .sin_i(sin_line), .sin_o(sin_o), .sin_oe(sin_oe), .sout_o(sout_o),
        .sout_oe(sout_oe)
    );

    ssp_link_model u_link (
        .scl_line(scl_line), .sout_line(sout_line), .scl_drv(scl_drv), .sin_drv(sin_drv)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one single transfer; the master waits for hready without assuming a latency
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        int k;
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {2'b00, idx, 2'b00};
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) errors++;
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) errors++;
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] t;
        bus(1'b1, idx, d, t);
        repeat (2) @(posedge hclk);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d);
        bus(1'b0, idx, 32'h0, d);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        rd(idx, d);
        check(d, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check(32'(shift_irq_n), 32'h1);
        check(32'({irq, hresp, scl_oe, sin_oe, sout_oe}), 32'h0);
        rdchk(SSP_IDX_CTRL, 32'h02);
        rdchk(SSP_IDX_PINS, 32'h03);
        rdchk(8'h10, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_byte();
        logic [7:0]  rx;
        logic [31:0] d;
        wr(SSP_IDX_CTRL, 32'h06);
        wr(SSP_IDX_MASK, 32'h01);
        wr(SSP_IDX_SHIFT_DATA, 32'ha5);
        u_link.clk_bits(8, 8'h3c, rx);
        repeat (6) @(posedge hclk);
        check(32'(rx), 32'ha5);
        check(32'(shift_irq_n), 32'h0);
        check(32'(irq), 32'h1);
        rdchk(SSP_IDX_SHIFT_DATA, 32'h3c);
        rd(SSP_IDX_PINS, d);
        check(32'(d[7:3]), 32'h11);
        u_link.clk_bits(8, 8'hff, rx);
        rdchk(SSP_IDX_SHIFT_DATA, 32'h3c);
        wr(SSP_IDX_MASK, 32'h00);
        check(32'(irq), 32'h0);
        wr(SSP_IDX_STAT, 32'h07);
        wr(SSP_IDX_MASK, 32'h01);
        check(32'(irq), 32'h0);
        $display("test byte done");
    endtask

    task automatic t_rearm();
        logic [7:0]  rx;
        logic [31:0] d;
        wr(SSP_IDX_SHIFT_DATA, 32'h81);
        check(32'(shift_irq_n), 32'h1);
        u_link.clk_bits(5, 8'h00, rx);
        wr(SSP_IDX_SHIFT_DATA, 32'h81);
        rd(SSP_IDX_PINS, d);
        check(32'(d[7:4]), 32'h0);
        u_link.clk_bits(3, 8'h00, rx);
        check(32'(shift_irq_n), 32'h1);
        u_link.clk_bits(5, 8'h00, rx);
        repeat (6) @(posedge hclk);
        check(32'(shift_irq_n), 32'h0);
        wr(SSP_IDX_INT_DISABLE, 32'h5a);
        check(32'(shift_irq_n), 32'h1);
        wr(SSP_IDX_SHIFT_DATA, 32'h00);
        wr(SSP_IDX_INT_DISABLE, 32'h00);
        wr(SSP_IDX_STAT, 32'h07);
        u_link.clk_bits(8, 8'hc3, rx);
        repeat (6) @(posedge hclk);
        check(32'(shift_irq_n), 32'h1);
        rdchk(SSP_IDX_SHIFT_DATA, 32'hc3);
        rd(SSP_IDX_STAT, d);
        check(32'(d[0]), 32'h0);
        $display("test rearm done");
    endtask

    task automatic t_master();
        wr(SSP_IDX_CTRL, 32'h03);
        wr(SSP_IDX_SHIFT_DATA, 32'h00);
        for (int i = 0; i < 8; i++) begin
            wr(SSP_IDX_CTRL, 32'h01);
            check(32'(scl_line), 32'h0);
            repeat (4) @(posedge hclk);
            wr(SSP_IDX_CTRL, 32'h03);
            repeat (4) @(posedge hclk);
        end
        rdchk(SSP_IDX_SHIFT_DATA, 32'hff);
        check(32'(shift_irq_n), 32'h0);
        wr(SSP_IDX_CTRL, 32'h02);
        $display("test master done");
    endtask

    task automatic t_stretch_ack();
        logic [31:0] d;
        wr(SSP_IDX_CTRL, 32'h1a);
        check(32'(scl_line), 32'h0);
        check(32'(sin_line), 32'h0);
        repeat (4) @(posedge hclk);
        rd(SSP_IDX_PINS, d);
        check(32'(d[1:0]), 32'h0);
        wr(SSP_IDX_CTRL, 32'h02);
        check(32'({scl_line, sin_line}), 32'h3);
        $display("test stretch done");
    endtask

    task automatic t_start_stop();
        logic [31:0] d;
        wr(SSP_IDX_STAT, 32'h07);
        wr(SSP_IDX_MASK, 32'h02);
        u_link.start_cond();
        repeat (4) @(posedge hclk);
        check(32'(irq), 32'h1);
        rd(SSP_IDX_STAT, d);
        check(32'(d[2:1]), 32'h1);
        wr(SSP_IDX_STAT, 32'h02);
        u_link.stop_cond();
        repeat (4) @(posedge hclk);
        rd(SSP_IDX_STAT, d);
        check(32'(d[2:1]), 32'h2);
        $display("test start stop done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // whole run is well under a quarter of this span
    initial begin
        #2ms;
        errors++;
        final_report();
    end

    initial begin
        hresetn  = 1'b0;
        hsel     = 1'b0;
        haddr    = '0;
        htrans   = 2'b00;
        hwrite   = 1'b0;
        hwdata   = '0;
        errors   = 0;
        n_checks = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_byte();
        t_rearm();
        t_master();
        t_stretch_ack();
        t_start_stop();
        final_report();
    end
endmodule
